/* File: hdl/rtcw_pkg.sv */
// types shared by the wake-up timer and its bench
`default_nettype none

package rtcw_pkg;

  // ========================================================================
  // bus carriers
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } rtcw_apb_req_type;

  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
  } rtcw_apb_rsp_type;

  // ========================================================================
  // command buffer phases
  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_PEND,
    CMD_DONE
  } rtcw_cmd_type;

  // ========================================================================
  // complete block state
  typedef struct packed {
    logic [2:0]   osc_sync;
    logic [1:0]   gate_sync;
    logic         en;
    logic         auto_go;
    logic         start;
    logic         running;
    logic [15:0]  div;
    logic [23:0]  sleep;
    logic [23:0]  remain;
    logic [15:0]  presc;
    logic         allow;
    logic         raw;
    logic [31:0]  elapsed;
    rtcw_cmd_type phase;
    logic [11:0]  cmd_addr;
    logic [31:0]  cmd_data;
    logic [31:0]  rdata;
    logic         slverr;
  } rtcw_state_type;

endpackage

`default_nettype wire

/* File: hdl/rtcw_regs.svh */
// register offsets, field positions and reset values of the wake-up timer
`ifndef RTCW_REGS_SVH
`define RTCW_REGS_SVH

// ==========================================================================
// offsets
`define RTCW_OFF_CTRL     12'h000
`define RTCW_OFF_STATUS   12'h004
`define RTCW_OFF_DIV      12'h008
`define RTCW_OFF_SLEEP    12'h00c
`define RTCW_OFF_REMAIN   12'h010
`define RTCW_OFF_ALLOW    12'h014
`define RTCW_OFF_RAW      12'h018
`define RTCW_OFF_GATED    12'h01c
`define RTCW_OFF_CLEAR    12'h020
`define RTCW_OFF_READY    12'h024
`define RTCW_OFF_ELAPSED  12'h030

// ==========================================================================
// field positions
`define RTCW_CTRL_EN      0
`define RTCW_CTRL_AUTO    1
`define RTCW_CTRL_START   2
`define RTCW_STAT_EN      0
`define RTCW_STAT_GATE    1
`define RTCW_STAT_FREEZE  2
`define RTCW_STAT_RUN     3
`define RTCW_IRQ_BIT      0

// ==========================================================================
// reset values
`define RTCW_RST_EN       1'h0
`define RTCW_RST_AUTO     1'h1
`define RTCW_RST_DIV      16'h8000
`define RTCW_RST_SLEEP    24'h000000
`define RTCW_RST_ELAPSED  32'h00000000

`endif

/* File: hdl/rtcw_timer.sv */
// always-on countdown wake-up timer with buffered apb register access
`default_nettype none
`include "rtcw_regs.svh"

module rtcw_timer #(
  // widths fixed by the state struct and the register map
  parameter int unsigned DIV_WIDTH   = 16,
  parameter int unsigned COUNT_WIDTH = 24
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // register bus
  input  wire rtcw_pkg::rtcw_apb_req_type i_apb,
  output var  rtcw_pkg::rtcw_apb_rsp_type o_apb,
  // slow oscillator and power-unit gate, both asynchronous
  input  wire logic                      i_slow_osc_clock,
  input  wire logic                      i_timer_clock_gate,
  // wake-up interrupt line
  output      logic                      o_wake_irq
);

  // ========================================================================
  // elaboration checks
  // the packed state holds 16 divisor bits and 24 count bits, nothing else
  if (DIV_WIDTH != 16) begin : g_div_width
    $error("divisor width other than 16 is not supported");
  end
  if (COUNT_WIDTH != 24) begin : g_count_width
    $error("count width other than 24 is not supported");
  end

  // ========================================================================
  // state
  rtcw_pkg::rtcw_state_type s;
  rtcw_pkg::rtcw_state_type next_s;

  logic        osc_rise;
  logic        gate_on;
  logic        pulse;
  logic        last;
  logic        freeze;
  logic        tick;
  logic        expire;
  logic        set_raw;
  logic        clr_raw;
  logic        apply;
  logic        setup;
  logic        wr_acc;
  logic        mapped;
  logic        writable;
  logic        hold_sleep;
  logic [31:0] rd_mux;
  logic [16:0] presc_inc;

  // ========================================================================
  // slow-domain sampling
  // osc_sync[0] and gate_sync[0] feed only the next stage
  assign osc_rise = s.osc_sync[1] & ~s.osc_sync[2];
  assign gate_on  = s.gate_sync[1];
  // pulses counted only while enabled and the gate supplies them
  assign pulse    = osc_rise & gate_on & s.en;
  assign presc_inc = {1'h0, s.presc} + 17'h00001;
  // divisor of zero ticks on every pulse rather than never
  assign last     = presc_inc >= {1'h0, s.div};
  assign tick     = pulse & last;
  // set through the whole prescaler step that ends in a tick, so a sleep load never meets a decrement
  // divisors 0 and 1 tick on every pulse; holding then would never end,
  // so those short settings accept the load and let it win over the tick
  assign freeze   = s.en & gate_on & last & (s.div > 16'h0001);

  // ========================================================================
  // bus decode
  assign setup  = i_apb.sel & ~i_apb.enable;
  assign wr_acc = i_apb.sel & i_apb.enable & i_apb.write;
  // reads answer at once from live state; only writes wait for a slow edge

  always_comb begin
    mapped   = 1'b1;
    writable = 1'b0;
    rd_mux   = 32'h00000000;
    unique case (i_apb.addr)
      `RTCW_OFF_CTRL: begin
        writable = 1'b1;
        rd_mux[`RTCW_CTRL_EN]    = s.en;
        rd_mux[`RTCW_CTRL_AUTO]  = s.auto_go;
        rd_mux[`RTCW_CTRL_START] = s.start;
      end
      `RTCW_OFF_STATUS: begin
        rd_mux[`RTCW_STAT_EN]     = s.en;
        rd_mux[`RTCW_STAT_GATE]   = gate_on;
        rd_mux[`RTCW_STAT_FREEZE] = freeze;
        rd_mux[`RTCW_STAT_RUN]    = s.running & s.en & gate_on;
      end
      `RTCW_OFF_DIV: begin
        writable     = 1'b1;
        rd_mux[15:0] = s.div;
      end
      `RTCW_OFF_SLEEP: begin
        writable     = 1'b1;
        rd_mux[23:0] = s.sleep;
      end
      `RTCW_OFF_REMAIN: begin
        rd_mux[23:0] = s.remain;
      end
      `RTCW_OFF_ALLOW: begin
        writable               = 1'b1;
        rd_mux[`RTCW_IRQ_BIT]  = s.allow;
      end
      `RTCW_OFF_RAW: begin
        rd_mux[`RTCW_IRQ_BIT] = s.raw;
      end
      `RTCW_OFF_GATED: begin
        rd_mux[`RTCW_IRQ_BIT] = s.raw & s.allow;
      end
      `RTCW_OFF_CLEAR: begin
        writable = 1'b1;
      end
      `RTCW_OFF_READY: begin
        rd_mux[`RTCW_IRQ_BIT] = (s.phase == rtcw_pkg::CMD_IDLE);
      end
      `RTCW_OFF_ELAPSED: begin
        writable = 1'b1;
        rd_mux   = s.elapsed;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // command buffer timing
  // the buffer stands for the crossing into the always-on core: bus
  // writes reach core state only on a slow edge, one at a time
  // sleep writes stall in the buffer while the count is near a tick edge
  assign hold_sleep = (s.cmd_addr == `RTCW_OFF_SLEEP) & freeze;
  assign apply = osc_rise & (s.phase == rtcw_pkg::CMD_PEND) & ~hold_sleep;

  // ========================================================================
  // next state
  always_comb begin
    next_s  = s;
    expire  = 1'b0;
    clr_raw = 1'b0;

    // two-stage synchronisers, third stage only for edge detection
    next_s.osc_sync  = {s.osc_sync[1:0], i_slow_osc_clock};
    next_s.gate_sync = {s.gate_sync[0], i_timer_clock_gate};

    // prescaler and elapsed-time counter
    // a divisor lowered below the current count ends that count at the next pulse
    if (pulse) begin
      if (last) begin
        next_s.presc = 16'h0000;
      end else begin
        next_s.presc = presc_inc[15:0];
      end
    end
    if (tick) begin
      next_s.elapsed = s.elapsed + 32'h00000001;
    end

    // countdown
    if (tick & s.running) begin
      if (s.remain <= 24'h000001) begin
        next_s.remain = 24'h000000;
        expire        = 1'b1;
      end else begin
        next_s.remain = s.remain - 24'h000001;
      end
    end

    // buffered command, applied on a slow edge
    if (osc_rise & (s.phase == rtcw_pkg::CMD_DONE)) begin
      next_s.phase = rtcw_pkg::CMD_IDLE;
    end
    if (apply) begin
      next_s.phase = rtcw_pkg::CMD_DONE;
      unique case (s.cmd_addr)
        `RTCW_OFF_CTRL: begin
          next_s.en      = s.cmd_data[`RTCW_CTRL_EN];
          next_s.auto_go = s.cmd_data[`RTCW_CTRL_AUTO];
          // a restart in an expiry cycle wins and that done event is lost
          if (s.cmd_data[`RTCW_CTRL_START]) begin
            next_s.start   = 1'b1;
            next_s.running = 1'b1;
            next_s.remain  = s.sleep;
            expire         = (s.sleep == 24'h000000);
          end else begin
            next_s.start = 1'b0;
          end
        end
        `RTCW_OFF_DIV: begin
          next_s.div = s.cmd_data[15:0];
        end
        `RTCW_OFF_SLEEP: begin
          next_s.sleep = s.cmd_data[23:0];
          next_s.start = 1'b0;
          if (s.auto_go) begin
            next_s.running = 1'b1;
            next_s.remain  = s.cmd_data[23:0];
            expire         = (s.cmd_data[23:0] == 24'h000000);
          end
        end
        `RTCW_OFF_ALLOW: begin
          next_s.allow = s.cmd_data[`RTCW_IRQ_BIT];
        end
        `RTCW_OFF_CLEAR: begin
          clr_raw = s.cmd_data[`RTCW_IRQ_BIT];
        end
        `RTCW_OFF_ELAPSED: begin
          next_s.elapsed = s.cmd_data;
        end
        default: begin
          next_s.phase = rtcw_pkg::CMD_DONE;
        end
      endcase
    end

    // expiry: stop, drop the start bit, flag the done condition while enabled
    if (expire) begin
      next_s.running = 1'b0;
      next_s.start   = 1'b0;
    end
    set_raw = expire & s.en;

    // a done event in the clearing cycle is kept
    if (clr_raw) begin
      next_s.raw = 1'b0;
    end
    if (set_raw) begin
      next_s.raw = 1'b1;
    end

    // bus read data latched in the setup phase
    if (setup) begin
      next_s.rdata  = rd_mux;
      next_s.slverr = ~mapped;
    end

    // one command in flight; later writes are dropped until ready
    if (wr_acc & writable & (s.phase == rtcw_pkg::CMD_IDLE)) begin
      next_s.phase    = rtcw_pkg::CMD_PEND;
      next_s.cmd_addr = i_apb.addr;
      next_s.cmd_data = i_apb.wdata;
    end
  end

  // ========================================================================
  // registers
  // async so the core is quiet before the slow oscillator first runs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s          <= '0;
      s.en       <= `RTCW_RST_EN;
      s.auto_go  <= `RTCW_RST_AUTO;
      s.div      <= `RTCW_RST_DIV;
      s.sleep    <= `RTCW_RST_SLEEP;
      s.elapsed  <= `RTCW_RST_ELAPSED;
      s.phase    <= rtcw_pkg::CMD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================================
  // outputs
  // single bus cycle; the slow transfer shows only through the ready flag
  assign o_apb.rdata  = s.rdata;
  assign o_apb.ready  = 1'b1;
  assign o_apb.slverr = s.slverr & i_apb.sel & i_apb.enable;
  // the always-on side keeps raising wake even with the bus unpowered
  assign o_wake_irq   = s.raw & s.allow & s.en;

endmodule

`default_nettype wire

/* File: tb/rtcw_host.sv */
// processor model issuing register accesses to the wake-up timer
`default_nettype none
`include "rtcw_regs.svh"

module rtcw_host (
  // clock
  input  wire logic                       i_clk,
  // register bus
  output var  rtcw_pkg::rtcw_apb_req_type o_req,
  input  wire rtcw_pkg::rtcw_apb_rsp_type i_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // bus cycles
  initial o_req = '0;
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    int n;
    @(posedge i_clk);
    #1 o_req = '{sel:1'b1, enable:1'b0, write:w, addr:a, wdata:wd};
    @(posedge i_clk);
    #1 o_req.enable = 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_rsp.ready !== 1'b1 && n < 8);
    if (i_rsp.ready === 1'b1) begin
      rd  = i_rsp.rdata;
      err = i_rsp.slverr;
    end else begin
      // an unanswered access poisons the result so the caller counts it
      rd  = 'x;
      err = 1'bx;
    end
    // released lines carry junk so stale values are never relied on
    #1 o_req = '{sel:1'b0, enable:1'b0, write:~w, addr:~a, wdata:~wd};
  endtask
  task automatic poll(output logic ok);
    logic [31:0] d;
    logic        e;
    ok = 1'b0;
    for (int n = 0; n < 100 && ok !== 1'b1; n++) begin
      xfer(1'b0, `RTCW_OFF_READY, 32'h0, d, e);
      ok = d[0];
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic ok);
    logic [31:0] q;
    logic        e;
    logic        ok2;
    poll(ok);
    xfer(1'b1, a, d, q, e);
    poll(ok2);
    ok = ok & ok2 & (e === 1'b0);
  endtask
endmodule

`default_nettype wire

/* File: tb/rtcw_monitor.sv */
// port checker for the wake-up timer
`default_nettype none
`include "rtcw_regs.svh"

module rtcw_monitor (
  // clock and reset
  input wire logic                       i_clk,
  input wire logic                       i_rst,
  // register bus
  input wire rtcw_pkg::rtcw_apb_req_type i_apb,
  input wire rtcw_pkg::rtcw_apb_rsp_type o_apb,
  // slow side and interrupt
  input wire logic                       i_slow_osc_clock,
  input wire logic                       i_timer_clock_gate,
  input wire logic                       o_wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // helpers and assertions
  logic [3:0] osc_hist;
  logic       rd_acc;
  assign rd_acc = i_apb.sel & i_apb.enable & ~i_apb.write;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) osc_hist <= 4'h0;
    else osc_hist <= {osc_hist[2:0], i_slow_osc_clock};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_ready_high: assert property (o_apb.ready)
    else $error("ready dropped");
  a_err_in_access: assert property (
    o_apb.slverr |-> i_apb.sel && i_apb.enable) else $error("stray slverr");
  a_err_unmapped: assert property (
    rd_acc && i_apb.addr == 12'h028 |-> o_apb.slverr) else $error("no slverr");
  a_mapped_ok: assert property (
    i_apb.sel && i_apb.enable && i_apb.addr <= `RTCW_OFF_READY
    |-> !o_apb.slverr) else $error("slverr on mapped");
  a_rdata_holds: assert property (rd_acc |=> $stable(o_apb.rdata))
    else $error("read data moved");
  a_remain_width: assert property (
    rd_acc && i_apb.addr == `RTCW_OFF_REMAIN |-> o_apb.rdata[31:24] == 8'h00)
    else $error("remain upper bits");
  a_ready_bits: assert property (
    rd_acc && i_apb.addr == `RTCW_OFF_READY |-> o_apb.rdata[31:1] == 31'h0)
    else $error("ready flag upper bits");
  // irq moves only when a pin rise three clocks back has reached the core
  a_irq_on_slow: assert property (
    $changed(o_wake_irq) |-> osc_hist[2] && !osc_hist[3])
    else $error("irq moved without slow edge");
  a_reset_quiet: assert property (@(posedge i_clk) disable iff (1'b0)
    i_rst |-> !o_wake_irq && o_apb.rdata == 32'h0) else $error("reset not quiet");
endmodule

bind rtcw_timer rtcw_monitor i_rtcw_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
  .i_slow_osc_clock(i_slow_osc_clock),
  .i_timer_clock_gate(i_timer_clock_gate), .o_wake_irq(o_wake_irq));

`default_nettype wire

/* File: tb/rtcw_timer_bench.sv */
// self-checking bench for the wake-up timer
`default_nettype none
`include "rtcw_regs.svh"

module rtcw_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // clocks, design and helpers
  logic                       clk = 1'b0;
  logic                       rst = 1'b0;
  logic                       osc = 1'b0;
  logic                       gate = 1'b1;
  logic                       irq;
  rtcw_pkg::rtcw_apb_req_type req;
  rtcw_pkg::rtcw_apb_rsp_type rsp;
  int                         num_errors = 0;
  int                         comparisons = 0;
  always #10 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    #1 osc = ~osc;
  end
  rtcw_timer i_rtcw_timer (.i_clk(clk), .i_rst(rst), .i_apb(req),
    .o_apb(rsp), .i_slow_osc_clock(osc), .i_timer_clock_gate(gate),
    .o_wake_irq(irq));
  rtcw_host i_rtcw_host (.i_clk(clk), .o_req(req), .i_rsp(rsp));

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic ok;
    i_rtcw_host.wr(a, d, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    i_rtcw_host.xfer(1'b0, a, 32'h0, d, e);
  endtask
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] d;
    rd(a, d);
    chk(n, d, x);
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge clk);
    if (irq !== 1'b1) begin
      num_errors++;
      summarize();
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    logic        e;
    rc("control", `RTCW_OFF_CTRL, 32'h00000002);
    rc("status", `RTCW_OFF_STATUS, 32'h00000002);
    rc("divider", `RTCW_OFF_DIV, 32'h00008000);
    rc("sleep", `RTCW_OFF_SLEEP, 32'h0);
    rc("remain", `RTCW_OFF_REMAIN, 32'h0);
    rc("allow", `RTCW_OFF_ALLOW, 32'h0);
    rc("raw", `RTCW_OFF_RAW, 32'h0);
    rc("gated", `RTCW_OFF_GATED, 32'h0);
    rc("clear", `RTCW_OFF_CLEAR, 32'h0);
    rc("ready", `RTCW_OFF_READY, 32'h1);
    i_rtcw_host.xfer(1'b0, 12'h028, 32'h0, d, e);
    chk("unmapped", {d[31:1], e}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_countdown();
    logic [31:0] d;
    w(`RTCW_OFF_DIV, 32'hffff0002);
    rc("divider", `RTCW_OFF_DIV, 32'h00000002);
    w(`RTCW_OFF_ALLOW, 32'h1);
    w(`RTCW_OFF_CTRL, 32'h3);
    w(`RTCW_OFF_SLEEP, 32'h3);
    rd(`RTCW_OFF_STATUS, d);
    chk("status run", d & 32'hfffffffb, 32'h0000000b);
    wait_irq();
    rc("raw", `RTCW_OFF_RAW, 32'h1);
    rc("gated", `RTCW_OFF_GATED, 32'h1);
    rc("remain", `RTCW_OFF_REMAIN, 32'h0);
    rc("control", `RTCW_OFF_CTRL, 32'h3);
    w(`RTCW_OFF_REMAIN, 32'h5);
    rc("remain ro", `RTCW_OFF_REMAIN, 32'h0);
    w(`RTCW_OFF_CLEAR, 32'h1);
    rc("raw cleared", `RTCW_OFF_RAW, 32'h0);
    chk("irq cleared", irq, 32'h0);
    $display("countdown test done");
  endtask
  task automatic t_manual();
    w(`RTCW_OFF_CTRL, 32'h1);
    w(`RTCW_OFF_SLEEP, 32'h2);
    // longer than sleep times divider slow pulses
    repeat (64) @(posedge clk);
    rc("no write_triggers_countdown", `RTCW_OFF_RAW, 32'h0);
    w(`RTCW_OFF_CTRL, 32'h5);
    wait_irq();
    rc("start cleared", `RTCW_OFF_CTRL, 32'h1);
    w(`RTCW_OFF_ALLOW, 32'h0);
    chk("irq masked", irq, 32'h0);
    rc("raw unmasked", `RTCW_OFF_RAW, 32'h1);
    rc("gated masked", `RTCW_OFF_GATED, 32'h0);
    w(`RTCW_OFF_CLEAR, 32'h1);
    $display("manual start test done");
  endtask
  task automatic t_disabled();
    w(`RTCW_OFF_CTRL, 32'h2);
    w(`RTCW_OFF_ALLOW, 32'h1);
    w(`RTCW_OFF_SLEEP, 32'h1);
    repeat (64) @(posedge clk);
    chk("irq off", irq, 32'h0);
    rc("raw off", `RTCW_OFF_RAW, 32'h0);
    rc("status off", `RTCW_OFF_STATUS, 32'h2);
    w(`RTCW_OFF_ELAPSED, 32'h12345678);
    rc("elapsed held", `RTCW_OFF_ELAPSED, 32'h12345678);
    gate = 1'b0;
    // two clocks for the gate to cross the synchroniser
    repeat (2) @(posedge clk);
    rc("gate mirror", `RTCW_OFF_STATUS, 32'h0);
    gate = 1'b1;
    $display("disabled test done");
  endtask

  initial begin
    // a real reset edge, so the design leaves its unknown power-up state
    #1 rst = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_countdown();
    t_manual();
    t_disabled();
    summarize();
  end
endmodule

`default_nettype wire
